// File: ces_top.v
// Contract
// RULE1 - Cyclic servicing begins only after every attached module is recognised.
// RULE2 - In run or monitor startup mode the device stays in standby until recognition.
// RULE3 - A startup configuration error sends the device to a lit-error standby until power cycles.
// RULE4 - Startup standby shows all indicators off; a fatal error shows ready and error lit, run off.
// RULE5 - Of simultaneous errors only the most serious code is stored in the error-code word.
// RULE6 - A fatal error clears I/O memory unless raised by the user fatal-alarm instruction.
// RULE7 - When operation stops every output is turned off.
// RULE8 - A memory fault records code 80F1, sets flag bit 15 and one memory location bit.
// RULE9 - Memory location bits are 0 program, 4 setup, 10 flash, 13 analog data, 14 stored DM.
// RULE10 - A bus transfer failure or missing end cover sets flag bit 14 and a bus error code.
// RULE11 - A bus error stores slot number in the low byte and rack number in the high byte.
// RULE12 - Both bytes hold 0D for sync error, 0E for missing end cover, 0F for unknown slot.
// RULE13 - Error words and flags are cleared at reset and set only by detected errors.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ces_defines.vh"
module ces_top (
  input  wire                     ref_clk,
  input  wire                     rst_b,
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [`CES_ADDR_W-1:0]   paddr,
  input  wire [31:0]              pwdata,
  output reg  [31:0]              prdata,
  output reg                      pready,
  output reg                      pslverr,
  input  wire                     modules_recognised,
  input  wire [1:0]               startup_mode,
  input  wire                     too_many_io_err,
  input  wire                     unit_number_err,
  input  wire                     dup_number_err,
  input  wire                     io_setting_err,
  input  wire [4:0]               mem_fault,
  input  wire                     bus_fault,
  input  wire [1:0]               bus_fault_kind,
  input  wire [3:0]               bus_fault_slot,
  input  wire                     bus_fault_rack,
  input  wire                     user_fatal_alarm_instruction,
  input  wire [8:0]               user_fatal_alarm_number,
  output reg                      ready_led,
  output reg                      run_led,
  output reg                      err_led,
  output reg                      cyclic_active,
  output reg                      outputs_on,
  output reg                      io_mem_clear,
  output reg                      irq
);
  localparam [3:0] ST_STANDBY = 4'h1;
  localparam [3:0] ST_RUN     = 4'h2;
  localparam [3:0] ST_FATAL   = 4'h4;
  localparam [3:0] ST_HALT    = 4'h8;

  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [15:0] err_code;
  reg  [15:0] next_err_code;
  reg  [15:0] err_flags;
  reg  [15:0] next_err_flags;
  reg  [15:0] mem_loc;
  reg  [15:0] next_mem_loc;
  reg  [15:0] bus_loc;
  reg  [15:0] next_bus_loc;
  reg  [2:0]  irq_sts;
  reg  [2:0]  next_irq_sts;
  reg  [2:0]  irq_msk;
  reg  [2:0]  evt;
  wire        recog_s;
  wire [1:0]  mode_s;
  wire [15:0] prio_code;
  wire        prio_user_fatal_alarm_instruction;
  wire        mem_any;
  wire        startup_err;
  wire        fatal_evt;
  wire        apb_setup;
  wire        apb_done;
  wire        rd_sts_clr;
  wire        wr_msk;
  wire        mode_runs;

  ces_sync #(
    .W (3)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .async_in ({startup_mode, modules_recognised}),
    .sync_out ({mode_s, recog_s})
  );

  assign mem_any     = |mem_fault;
  assign startup_err = too_many_io_err | unit_number_err |
                       dup_number_err | io_setting_err;
  assign fatal_evt   = mem_any | bus_fault | user_fatal_alarm_instruction;
  assign mode_runs   = (mode_s == `CES_MODE_RUN) ||
                       (mode_s == `CES_MODE_MONITOR);

  ces_prio u_prio (
    .mem_err      (mem_any),
    .bus_err      (bus_fault),
    .bus_kind     (bus_fault_kind),
    .ioset_err    (io_setting_err),
    .dup_err      (dup_number_err | unit_number_err),
    .too_many_err (too_many_io_err),
    .user_fatal_alarm_instruction_err     (user_fatal_alarm_instruction),
    .user_fatal_alarm_instruction_num     (user_fatal_alarm_number),
    .code         (prio_code),
    .user_fatal_alarm_instruction_only    (prio_user_fatal_alarm_instruction)
  );

  // Bus error location word
  function [15:0] bus_loc_word;
    input [1:0] kind;
    input [3:0] slot;
    input       rack;
    begin
      case (kind)
        `CES_BUS_SYNC:  bus_loc_word = {`CES_LOC_SYNC, `CES_LOC_SYNC};
        `CES_BUS_ENDC:  bus_loc_word = {`CES_LOC_ENDC, `CES_LOC_ENDC};
        `CES_BUS_UNDET: bus_loc_word = {`CES_LOC_UNDET, `CES_LOC_UNDET};
        default:        bus_loc_word = {7'h00, rack, 4'h0, slot};
      endcase
    end
  endfunction

  // Memory location bits from fault vector
  function [15:0] mem_loc_bits;
    input [4:0] f;
    begin
      mem_loc_bits = 16'h0000;
      mem_loc_bits[`CES_MLOC_PROG]   = f[0];
      mem_loc_bits[`CES_MLOC_SETUP]  = f[1];
      mem_loc_bits[`CES_MLOC_FLASH]  = f[2];
      mem_loc_bits[`CES_MLOC_ANALOG] = f[3];
      mem_loc_bits[`CES_MLOC_DM]     = f[4];
    end
  endfunction

  // Operating state sequence
  always @* begin
    next_state = state;
    evt        = 3'h0;
    case (state)
      ST_STANDBY: begin
        if (startup_err) begin
          next_state        = ST_HALT; // [RULE3]
          evt[`CES_IRQ_HALT] = 1'b1;
        end else if (fatal_evt) begin
          next_state          = ST_FATAL;
          evt[`CES_IRQ_FATAL] = 1'b1;
        end else if (recog_s) begin
          next_state          = ST_RUN; // [RULE1] [RULE2]
          evt[`CES_IRQ_READY] = 1'b1;
        end
      end
      ST_RUN: begin
        if (fatal_evt) begin
          next_state          = ST_FATAL;
          evt[`CES_IRQ_FATAL] = 1'b1;
        end
      end
      ST_FATAL: next_state = ST_FATAL;
      ST_HALT:  next_state = ST_HALT; // [RULE3]
      default:  next_state = ST_STANDBY;
    endcase
  end

  // Error capture on the entering edge of a stop state
  always @* begin
    next_err_code  = err_code;
    next_err_flags = err_flags;
    next_mem_loc   = mem_loc;
    next_bus_loc   = bus_loc;
    if (evt[`CES_IRQ_FATAL] || evt[`CES_IRQ_HALT]) begin
      next_err_code = prio_code; // [RULE5] [RULE8] [RULE10]
      if (mem_any) begin
        next_err_flags[`CES_FLG_MEM] = 1'b1; // [RULE8]
        next_mem_loc = mem_loc | mem_loc_bits(mem_fault); // [RULE9]
      end
      if (bus_fault) begin
        next_err_flags[`CES_FLG_BUS] = 1'b1; // [RULE10]
        next_bus_loc = bus_loc_word(bus_fault_kind, bus_fault_slot,
                                    bus_fault_rack); // [RULE11] [RULE12]
      end
      if (io_setting_err) begin
        next_err_flags[`CES_FLG_IOSET] = 1'b1;
      end
    end
  end

  // APB handshake: no wait cycle, data registered
  assign apb_setup  = psel & ~penable;
  assign apb_done   = psel & penable & pready;
  assign rd_sts_clr = apb_done & ~pwrite & (paddr == `CES_OFF_IRQ_STS);
  assign wr_msk     = apb_done & pwrite & (paddr == `CES_OFF_IRQ_MSK);

  // Sticky status, set wins over read clear
  always @* begin
    next_irq_sts = rd_sts_clr ? evt : (irq_sts | evt);
  end

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      state     <= ST_STANDBY;
      err_code  <= `CES_CODE_NONE; // [RULE13]
      err_flags <= 16'h0000;
      mem_loc   <= 16'h0000;
      bus_loc   <= 16'h0000;
      irq_sts   <= 3'h0;
      irq_msk   <= 3'h0;
      irq       <= 1'b0;
    end else begin
      state     <= next_state;
      err_code  <= next_err_code;
      err_flags <= next_err_flags;
      mem_loc   <= next_mem_loc;
      bus_loc   <= next_bus_loc;
      irq_sts   <= next_irq_sts;
      if (wr_msk) begin
        irq_msk <= pwdata[2:0];
      end
      irq <= |(next_irq_sts & (wr_msk ? pwdata[2:0] : irq_msk));
    end
  end

  // Indicators and output control
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      ready_led     <= 1'b0;
      run_led       <= 1'b0;
      err_led       <= 1'b0;
      cyclic_active <= 1'b0;
      outputs_on    <= 1'b0;
      io_mem_clear  <= 1'b0;
    end else begin
      case (next_state)
        ST_STANDBY: begin
          ready_led <= 1'b0; // [RULE4]
          run_led   <= 1'b0;
          err_led   <= 1'b0;
        end
        ST_RUN: begin
          ready_led <= 1'b1;
          run_led   <= mode_runs;
          err_led   <= 1'b0;
        end
        ST_FATAL: begin
          ready_led <= 1'b1; // [RULE4]
          run_led   <= 1'b0;
          err_led   <= 1'b1;
        end
        ST_HALT: begin
          ready_led <= 1'b0;
          run_led   <= 1'b0;
          err_led   <= 1'b1; // [RULE3]
        end
        default: begin
          ready_led <= 1'b0;
          run_led   <= 1'b0;
          err_led   <= 1'b0;
        end
      endcase
      cyclic_active <= (next_state == ST_RUN); // [RULE1]
      outputs_on    <= (next_state == ST_RUN) & mode_runs; // [RULE7]
      io_mem_clear  <= evt[`CES_IRQ_FATAL] & ~prio_user_fatal_alarm_instruction; // [RULE6]
    end
  end

  // APB read data and answer
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_setup;
      pslverr <= 1'b0;
      if (apb_setup) begin
        prdata <= 32'h00000000;
        case (paddr)
          `CES_OFF_CODE:    prdata <= {16'h0000, err_code};
          `CES_OFF_FLAGS:   prdata <= {16'h0000, err_flags};
          `CES_OFF_MEM_LOC: prdata <= {16'h0000, mem_loc};
          `CES_OFF_BUS_LOC: prdata <= {16'h0000, bus_loc};
          `CES_OFF_IRQ_STS: prdata <= {29'h00000000, irq_sts};
          `CES_OFF_IRQ_MSK: prdata <= {29'h00000000, irq_msk};
          `CES_OFF_STATE:   prdata <= {28'h0000000, state};
          default:          pslverr <= 1'b1;
        endcase
        if (pwrite && paddr != `CES_OFF_IRQ_MSK) begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: ces_defines.vh
`ifndef CES_DEFINES_VH
`define CES_DEFINES_VH

// APB register byte offsets
`define CES_ADDR_W            8
`define CES_OFF_CODE          8'h00
`define CES_OFF_FLAGS         8'h04
`define CES_OFF_MEM_LOC       8'h08
`define CES_OFF_BUS_LOC       8'h0C
`define CES_OFF_IRQ_STS       8'h10
`define CES_OFF_IRQ_MSK       8'h14
`define CES_OFF_STATE         8'h18

// Error flag word bit positions
`define CES_FLG_MEM           15
`define CES_FLG_BUS           14
`define CES_FLG_IOSET         10

// Memory error location bit positions
`define CES_MLOC_PROG         0
`define CES_MLOC_SETUP        4
`define CES_MLOC_FLASH        10
`define CES_MLOC_ANALOG       13
`define CES_MLOC_DM           14

// Error codes
`define CES_CODE_NONE         16'h0000
`define CES_CODE_MEM          16'h80F1
`define CES_CODE_BUS          16'h80C0
`define CES_CODE_BUS_SYNC     16'h80CD
`define CES_CODE_BUS_ENDC     16'h80CE
`define CES_CODE_BUS_UNDET    16'h80CF
`define CES_CODE_IOSET        16'h80E0
`define CES_CODE_DUP          16'h80E9
`define CES_CODE_TOO_MANY     16'h80E1
`define CES_CODE_USER_FATAL_ALARM_INSTRUCTION_BASE    16'hC100

// Bus error kinds and location fill bytes
`define CES_BUS_SLOT          2'h0
`define CES_BUS_SYNC          2'h1
`define CES_BUS_ENDC          2'h2
`define CES_BUS_UNDET         2'h3
`define CES_LOC_SYNC          8'h0D
`define CES_LOC_ENDC          8'h0E
`define CES_LOC_UNDET         8'h0F

// Startup modes
`define CES_MODE_PROGRAM      2'h0
`define CES_MODE_MONITOR      2'h1
`define CES_MODE_RUN          2'h2

// Interrupt status bits
`define CES_IRQ_FATAL         0
`define CES_IRQ_HALT          1
`define CES_IRQ_READY         2

`endif

// File: ces_sync.v
`timescale 1ns/100ps
`default_nettype none
module ces_sync #(
  parameter W = 1
) (
  input  wire         ref_clk,
  input  wire         rst_b,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;

  // Change accepted once second and third stages agree
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      stage1   <= {W{1'b0}};
      stage2   <= {W{1'b0}};
      stage3   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        sync_out <= stage3;
      end
    end
  end
endmodule
`default_nettype wire

// File: ces_prio.v
`timescale 1ns/100ps
`default_nettype none
`include "ces_defines.vh"
module ces_prio (
  input  wire        mem_err,
  input  wire        bus_err,
  input  wire [1:0]  bus_kind,
  input  wire        ioset_err,
  input  wire        dup_err,
  input  wire        too_many_err,
  input  wire        user_fatal_alarm_instruction_err,
  input  wire [8:0]  user_fatal_alarm_instruction_num,
  output reg  [15:0] code,
  output reg         user_fatal_alarm_instruction_only
);
  // Most serious error first
  always @* begin
    user_fatal_alarm_instruction_only = 1'b0;
    if (mem_err) begin
      code = `CES_CODE_MEM;
    end else if (bus_err) begin
      case (bus_kind)
        `CES_BUS_SYNC:  code = `CES_CODE_BUS_SYNC;
        `CES_BUS_ENDC:  code = `CES_CODE_BUS_ENDC;
        `CES_BUS_UNDET: code = `CES_CODE_BUS_UNDET;
        default:        code = `CES_CODE_BUS;
      endcase
    end else if (ioset_err) begin
      code = `CES_CODE_IOSET;
    end else if (dup_err) begin
      code = `CES_CODE_DUP;
    end else if (too_many_err) begin
      code = `CES_CODE_TOO_MANY;
    end else if (user_fatal_alarm_instruction_err) begin
      code      = `CES_CODE_USER_FATAL_ALARM_INSTRUCTION_BASE + {7'h00, user_fatal_alarm_instruction_num};
      user_fatal_alarm_instruction_only = 1'b1;
    end else begin
      code = `CES_CODE_NONE;
    end
  end
endmodule
`default_nettype wire

// File: ces_props.sv
`timescale 1ns/100ps
`default_nettype none
module ces_props (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       modules_recognised,
  input wire logic [4:0] mem_fault,
  input wire logic       bus_fault,
  input wire logic       user_fatal_alarm_instruction,
  input wire logic       ready_led,
  input wire logic       run_led,
  input wire logic       err_led,
  input wire logic       cyclic_active,
  input wire logic       outputs_on,
  input wire logic       io_mem_clear
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  wire hard = bus_fault || mem_fault != 5'h00;
  sequence s_fatal;
    ready_led && err_led && !run_led && !outputs_on && !cyclic_active;
  endsequence
  sequence s_halt;
    err_led && !ready_led && !run_led && !cyclic_active;
  endsequence
  sequence s_clr_once;
    io_mem_clear ##1 !io_mem_clear;
  endsequence
  AST_STANDBY_DARK: assert property (
    !cyclic_active && !err_led |-> !ready_led && !run_led && !outputs_on)
    else $error("standby lit");
  AST_RUN_AFTER_RECOG: assert property (
    $rose(cyclic_active) |-> $past(modules_recognised, 2))
    else $error("early run");
  AST_FATAL_SHOWN: assert property (
    cyclic_active && (hard || user_fatal_alarm_instruction) |=> s_fatal)
    else $error("fatal leds");
  AST_STOP_OUTPUTS: assert property (
    !cyclic_active |-> !outputs_on)
    else $error("outputs on");
  AST_CLEAR_ON_FAULT: assert property (
    cyclic_active && hard |=> s_clr_once)
    else $error("no clear");
  AST_ALARM_KEEPS: assert property (
    cyclic_active && user_fatal_alarm_instruction && !hard
      |=> !io_mem_clear [*2])
    else $error("alarm cleared");
  AST_HALT_FINAL: assert property (
    s_halt |=> s_halt)
    else $error("halt left");
  AST_FATAL_FINAL: assert property (
    s_fatal |=> s_fatal)
    else $error("fatal left");
  AST_CLEAR_IN_FATAL: assert property (
    $rose(io_mem_clear) |-> s_fatal)
    else $error("stray clear");
endmodule
`default_nettype wire

// File: ces_partner.sv
`timescale 1ns/100ps
`default_nettype none
module ces_partner (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] delay,
  output var  logic       modules_recognised
);
  logic [7:0] cnt;
  // Modules announce after a set time
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt <= 8'h00;
      modules_recognised <= 1'h0;
    end else if (cnt != delay) begin
      cnt <= cnt + 8'h01;
    end else begin
      modules_recognised <= 1'h1;
    end
  end
endmodule
`default_nettype wire

// File: ces_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ces_defines.vh"
module tb;
  reg         ref_clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0;
  reg         pwrite = 1'h0, bf = 1'h0, br = 1'h0, fa = 1'h0, se;
  reg  [7:0]  paddr = 8'h00, dly = 8'h04;
  reg  [31:0] pwdata = 32'h0, rd;
  reg  [1:0]  md = 2'h2, bk = 2'h0;
  reg  [3:0]  ser = 4'h0, bs = 4'h0;
  reg  [4:0]  mf = 5'h00;
  reg  [8:0]  fn = 9'h001;
  reg  [79:0] mt = 80'h4000_2000_0400_0010_0001;
  wire [31:0] prdata;
  wire        pready, pslverr, mr, rdy, run, err, cyc, oon, clr, irq;
  integer     num_errors = 0, n_compared = 0, tck = 0, i, n;
  ces_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modules_recognised(mr), .startup_mode(md), .too_many_io_err(ser[0]),
    .unit_number_err(ser[1]), .dup_number_err(ser[2]),
    .io_setting_err(ser[3]), .mem_fault(mf), .bus_fault(bf),
    .bus_fault_kind(bk), .bus_fault_slot(bs), .bus_fault_rack(br),
    .user_fatal_alarm_instruction(fa), .user_fatal_alarm_number(fn),
    .ready_led(rdy), .run_led(run), .err_led(err), .cyclic_active(cyc),
    .outputs_on(oon), .io_mem_clear(clr), .irq(irq));
  ces_partner u_mods (.ref_clk(ref_clk), .rst_b(rst_b), .delay(dly),
    .modules_recognised(mr));
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    tck <= tck + 1;
    if (tck == 30000) begin
      num_errors = num_errors + 1;
      stop_test;
    end
  end
  task stop_test;
    begin
      if (num_errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("BAD %0t %h %h", $time, g, e);
      end
    end
  endtask
  task tk;
    begin
      repeat (2) @(posedge ref_clk);
      #1;
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      n = 0;
      @(posedge ref_clk);
      while (pready !== 1'h1 && n < 20) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      rd = prdata;
      se = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n == 20) num_errors = num_errors + 1;
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    begin
      apb(1'h0, a, 32'h0);
      chk(rd, e);
    end
  endtask
  task boot(input [1:0] m, input [7:0] d);
    begin
      @(posedge ref_clk);
      rst_b <= 1'h0;
      md <= m;
      dly <= d;
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'h1;
      n = 0;
      #1;
      while (cyc !== 1'h1 && n < 60) begin
        @(posedge ref_clk);
        #1;
        n = n + 1;
      end
    end
  endtask
  task fault(input [4:0] m, input b, input a);
    begin
      @(posedge ref_clk);
      mf <= m;
      bf <= b;
      fa <= a;
      @(posedge ref_clk);
      mf <= 5'h00;
      bf <= 1'h0;
      fa <= 1'h0;
      #1;
    end
  endtask
  task t_start;
    begin
      boot(`CES_MODE_MONITOR, 8'h28);
      chk(n > 40, 32'h1);
      chk({run, err, cyc, oon}, 32'hB);
      for (i = 0; i < 16; i = i + 4) rc(i[7:0], 32'h0);
      boot(`CES_MODE_PROGRAM, 8'h04);
      chk({run, cyc, oon}, 32'h2);
    end
  endtask
  task t_halt;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge ref_clk);
        ser <= 4'h1 << i;
        boot(`CES_MODE_RUN, 8'h04);
        chk({rdy, run, err, cyc}, 32'h2);
        rc(`CES_OFF_CODE, i == 0 ? `CES_CODE_TOO_MANY : i == 3 ?
          `CES_CODE_IOSET : `CES_CODE_DUP);
        @(posedge ref_clk);
        ser <= 4'h0;
      end
    end
  endtask
  task t_bus;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        boot(`CES_MODE_RUN, 8'h04);
        @(posedge ref_clk);
        bk <= i[1:0];
        bs <= 4'h9;
        br <= 1'h1;
        fault(5'h00, 1'h1, 1'h0);
        chk({rdy, run, err, oon, clr}, 32'h15);
        rc(`CES_OFF_FLAGS, 32'h4000);
        rc(`CES_OFF_CODE, i == 0 ? 32'h80C0 : 32'h80CC + i);
        rc(`CES_OFF_BUS_LOC,
          i == 0 ? 32'h0109 : {2{8'h0C + i[7:0]}});
      end
    end
  endtask
  task t_mem;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        boot(`CES_MODE_RUN, 8'h04);
        fault(5'h01 << i, 1'h1, 1'h1);
        chk(clr, 32'h1);
        rc(`CES_OFF_CODE, `CES_CODE_MEM);
        apb(1'h0, `CES_OFF_FLAGS, 32'h0);
        chk(rd[15], 32'h1);
        rc(`CES_OFF_MEM_LOC, mt[i*16 +: 16]);
      end
    end
  endtask
  task t_alarm_irq;
    begin
      boot(`CES_MODE_RUN, 8'h04);
      apb(1'h1, `CES_OFF_IRQ_MSK, 32'h1);
      tk;
      chk(irq, 32'h0);
      apb(1'h1, `CES_OFF_IRQ_MSK, 32'h4);
      tk;
      chk(irq, 32'h1);
      rc(`CES_OFF_IRQ_STS, 32'h4);
      rc(`CES_OFF_IRQ_MSK, 32'h4);
      tk;
      chk(irq, 32'h0);
      apb(1'h1, `CES_OFF_CODE, 32'h1);
      chk(se, 32'h1);
      apb(1'h0, 8'h1C, 32'h0);
      chk(se, 32'h1);
      @(posedge ref_clk);
      fn <= 9'h1FF;
      fault(5'h00, 1'h0, 1'h1);
      chk({rdy, run, err, clr}, 32'hA);
      rc(`CES_OFF_CODE, `CES_CODE_USER_FATAL_ALARM_INSTRUCTION_BASE + 32'h1FF);
    end
  endtask
  initial begin
    t_start;
    t_halt;
    t_bus;
    t_mem;
    t_alarm_irq;
    stop_test;
  end
endmodule
bind ces_top ces_props u_props (.ref_clk(ref_clk), .rst_b(rst_b),
  .modules_recognised(modules_recognised), .mem_fault(mem_fault),
  .bus_fault(bus_fault),
  .user_fatal_alarm_instruction(user_fatal_alarm_instruction),
  .ready_led(ready_led), .run_led(run_led), .err_led(err_led),
  .cyclic_active(cyclic_active), .outputs_on(outputs_on),
  .io_mem_clear(io_mem_clear));
`default_nettype wire
